//--- design/dsw_defines.svh
/*
 contents: bit positions, reset values and scaling constants of the drive status word block.
 assumptions: included by bare name; definitions only.
*/
`ifndef DSW_DEFINES_SVH
`define DSW_DEFINES_SVH

// protocol selection value for the native drive protocol
`define DSW_PROTO_NATIVE 8'h00
// status word bit positions
`define DSW_BIT_CTRL_READY 0
`define DSW_BIT_DRIVE_READY 1
`define DSW_BIT_ENABLE 2
`define DSW_BIT_TRIP 3
`define DSW_BIT_ERROR 4
`define DSW_BIT_RESERVED 5
`define DSW_BIT_TRIPLOCK 6
`define DSW_BIT_WARNING 7
`define DSW_BIT_AT_REF 8
`define DSW_BIT_BUS_CTRL 9
`define DSW_BIT_FREQ_OK 10
`define DSW_BIT_RUNNING 11
`define DSW_BIT_AUTO_STOP 12
`define DSW_BIT_VOLTAGE 13
`define DSW_BIT_CURRENT 14
`define DSW_BIT_THERMAL 15
// reset values: not ready, nothing reported
`define DSW_STATE_RESET 16'h0000
`define DSW_WORD_RESET 16'h0000
// relative scaling: full scale word and thermal full scale
`define DSW_FULL_SCALE 16'h4000
`define DSW_THERMAL_FULL 16'h4000

`endif

//--- design/dsw_pkg.sv
/*
 contents: types shared by the drive status word block.
 assumptions: none beyond the defines header.
*/
package dsw_pkg;
   typedef logic [15:0] dsw_word_t;
   typedef enum logic [1:0] {
      DSW_ST_IDLE = 2'b00,
      DSW_ST_RUN = 2'b01,
      DSW_ST_TRIP = 2'b10,
      DSW_ST_LOCK = 2'b11
   } dsw_fault_state_t;
endpackage

//--- design/dsw_scale_if.sv
/*
 contents: interface carrying frequency scaling signals between the top and the scaler.
 assumptions: single clock domain.
*/
`timescale 1ns/1ps
interface dsw_scale_if;
   logic signed [15:0] freq_hz_x10;
   logic signed [15:0] max_hz_x10;
   logic signed [15:0] rel_word;
   modport top (output freq_hz_x10, output max_hz_x10, input rel_word);
   modport scaler (input freq_hz_x10, input max_hz_x10, output rel_word);
endinterface

//--- design/dsw_freq_scaler.sv
/*
 contents: converts an output frequency into a signed relative word, full scale 4000h.
 assumptions: max frequency positive; result saturates to the 16-bit signed range.
*/
`timescale 1ns/1ps
`include "dsw_defines.svh"
module dsw_freq_scaler (
   dsw_scale_if.scaler sc
);
   logic signed [31:0] prod;
   logic signed [31:0] quo;
   logic signed [15:0] den;

   // combinational divide; small block, timing relaxed at 50 MHz
   always_comb begin
      den = (sc.max_hz_x10 > 16'sh0000) ? sc.max_hz_x10 : 16'sh0001;
      prod = 32'(sc.freq_hz_x10) * 32'sd16384;
      quo = prod / 32'(den);
      // saturate rather than wrap so sign stays true
      if (quo > 32'sh00007FFF) begin
         sc.rel_word = 16'sh7FFF;
      end else if (quo < -32'sh00008000) begin
         sc.rel_word = -16'sh8000;
      end else begin
         sc.rel_word = quo[15:0];
      end
   end
endmodule

//--- design/dsw_status_word.sv
/*
 contents: drive status word builder, bus speed reference decoder and actual frequency word.
 assumptions: drive condition inputs come from other logic on clk except local_off_key, an
 asynchronous pin that is synchronised here; the fieldbus master reads the words and writes
 the reference word.
*/
`timescale 1ns/1ps
`include "dsw_defines.svh"
module dsw_status_word (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] protocol_select,
   input wire logic control_ready,
   input wire logic power_ready,
   input wire logic coast_active,
   input wire logic start_cmd,
   input wire logic trip_event,
   input wire logic triplock_event,
   input wire logic fault_reset,
   input wire logic error_no_trip,
   input wire logic warning_any,
   input wire logic local_mode,
   input wire logic local_off_key,
   input wire logic overtemp_stop,
   input wire logic dc_voltage_bad,
   input wire logic signed [15:0] output_freq,
   input wire logic signed [15:0] speed_ref_freq,
   input wire logic signed [15:0] low_limit,
   input wire logic signed [15:0] high_limit,
   input wire logic signed [15:0] max_freq,
   input wire logic [15:0] motor_current,
   input wire logic [15:0] current_limit,
   input wire logic [15:0] motor_thermal,
   input wire logic [15:0] drive_thermal,
   input wire logic [15:0] bus_ref_word,
   input wire logic bus_ref_write,
   output logic [15:0] drive_state_word,
   output logic status_valid,
   output logic signed [15:0] actual_output_frequency_value,
   output logic signed [31:0] speed_ref_ppm,
   output logic speed_ref_reverse
);
   ////////////////////////////////////////////////////////////////////////////
   // fault state machine: trip is sticky until reset, lock needs the reset input
   dsw_pkg::dsw_fault_state_t fault_st;
   dsw_pkg::dsw_fault_state_t next_fault_st;
   logic reset_q;
   logic next_reset_q;
   logic reset_rise;

   assign reset_rise = fault_reset & ~reset_q; // reset acts on the leading edge

   always_comb begin
      next_fault_st = fault_st;
      next_reset_q = fault_reset;
      unique case (fault_st)
         dsw_pkg::DSW_ST_IDLE: begin
            if (triplock_event) begin
               next_fault_st = dsw_pkg::DSW_ST_LOCK;
            end else if (trip_event) begin
               next_fault_st = dsw_pkg::DSW_ST_TRIP;
            end else if (control_ready) begin
               next_fault_st = dsw_pkg::DSW_ST_RUN;
            end
         end
         dsw_pkg::DSW_ST_RUN: begin
            if (triplock_event) begin
               next_fault_st = dsw_pkg::DSW_ST_LOCK;
            end else if (trip_event) begin
               next_fault_st = dsw_pkg::DSW_ST_TRIP;
            end else if (!control_ready) begin
               next_fault_st = dsw_pkg::DSW_ST_IDLE;
            end
         end
         dsw_pkg::DSW_ST_TRIP: begin
            // a new trip in the reset cycle wins over the reset
            if (triplock_event) begin
               next_fault_st = dsw_pkg::DSW_ST_LOCK;
            end else if (reset_rise && !trip_event) begin
               next_fault_st = dsw_pkg::DSW_ST_IDLE;
            end
         end
         dsw_pkg::DSW_ST_LOCK: begin
            next_fault_st = dsw_pkg::DSW_ST_LOCK; // only reset input leaves lock
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         fault_st <= dsw_pkg::DSW_ST_IDLE;
         reset_q <= 1'b0;
      end else begin
         fault_st <= next_fault_st;
         reset_q <= next_reset_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // off/reset key pin: three stages, change taken once stages two and three agree
   logic [2:0] key_sync;
   logic [2:0] next_key_sync;
   logic key_level;
   logic next_key_level;

   always_comb begin
      next_key_sync = {key_sync[1:0], local_off_key};
      next_key_level = key_level;
      if (key_sync[1] == key_sync[2]) begin
         next_key_level = key_sync[2];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         key_sync <= 3'h0;
         key_level <= 1'b0;
      end else begin
         key_sync <= next_key_sync;
         key_level <= next_key_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // actual frequency scaling through the helper module
   dsw_scale_if sc_bus ();
   assign sc_bus.freq_hz_x10 = output_freq;
   assign sc_bus.max_hz_x10 = max_freq;

   dsw_freq_scaler u_scaler (
      .sc(sc_bus)
   );

   ////////////////////////////////////////////////////////////////////////////
   // status word assembly
   logic [15:0] next_state_word;
   logic next_valid;
   logic tripped;
   logic locked;
   logic signed [15:0] next_actual;

   assign tripped = (fault_st == dsw_pkg::DSW_ST_TRIP) || (fault_st == dsw_pkg::DSW_ST_LOCK);
   assign locked = (fault_st == dsw_pkg::DSW_ST_LOCK);

   always_comb begin
      next_state_word = `DSW_STATE_RESET;
      next_valid = (protocol_select == `DSW_PROTO_NATIVE);
      next_actual = sc_bus.rel_word;
      if (next_valid) begin
         next_state_word[`DSW_BIT_CTRL_READY] = control_ready & ~tripped;
         next_state_word[`DSW_BIT_DRIVE_READY] = control_ready & power_ready & ~tripped & coast_active;
         next_state_word[`DSW_BIT_ENABLE] = ~coast_active;
         next_state_word[`DSW_BIT_TRIP] = tripped;
         next_state_word[`DSW_BIT_ERROR] = error_no_trip & ~tripped;
         next_state_word[`DSW_BIT_RESERVED] = 1'b0;
         next_state_word[`DSW_BIT_TRIPLOCK] = locked;
         next_state_word[`DSW_BIT_WARNING] = warning_any;
         next_state_word[`DSW_BIT_AT_REF] = (output_freq == speed_ref_freq);
         next_state_word[`DSW_BIT_BUS_CTRL] = ~local_mode & ~key_level;
         next_state_word[`DSW_BIT_FREQ_OK] = (output_freq > low_limit) && (output_freq < high_limit);
         next_state_word[`DSW_BIT_RUNNING] = start_cmd & ~coast_active & ~tripped;
         next_state_word[`DSW_BIT_AUTO_STOP] = overtemp_stop & ~tripped;
         next_state_word[`DSW_BIT_VOLTAGE] = dc_voltage_bad;
         next_state_word[`DSW_BIT_CURRENT] = (motor_current > current_limit);
         next_state_word[`DSW_BIT_THERMAL] = (motor_thermal > `DSW_THERMAL_FULL) ||
                                             (drive_thermal > `DSW_THERMAL_FULL);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         drive_state_word <= `DSW_WORD_RESET;
         status_valid <= 1'b0;
         actual_output_frequency_value <= 16'sh0000;
      end else begin
         drive_state_word <= next_state_word;
         status_valid <= next_valid;
         actual_output_frequency_value <= next_actual;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus speed reference: signed word, 4000h = 100 %, shown in parts per million
   logic signed [31:0] next_ref_ppm;
   logic next_reverse;

   // divide by 16384 is a shift, so no divider is spent here
   always_comb begin
      next_ref_ppm = speed_ref_ppm;
      next_reverse = speed_ref_reverse;
      if (bus_ref_write) begin
         next_ref_ppm = 32'((64'(signed'(bus_ref_word)) * 64'sd1000000) >>> 14);
         next_reverse = bus_ref_word[15];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         speed_ref_ppm <= 32'sh00000000;
         speed_ref_reverse <= 1'b0;
      end else begin
         speed_ref_ppm <= next_ref_ppm;
         speed_ref_reverse <= next_reverse;
      end
   end
endmodule

//--- sim/dsw_assertions.sv
/*
 holds the status word checker and its bind.
 assumes the dsw_status_word ports on one clock with synchronous reset.
*/
`timescale 1ns/1ps
module dsw_checker (
   input wire logic clk,
   input wire logic reset,
   input wire logic [7:0] protocol_select,
   input wire logic trip_event,
   input wire logic warning_any,
   input wire logic dc_voltage_bad,
   input wire logic [15:0] motor_current,
   input wire logic [15:0] current_limit,
   input wire logic [15:0] bus_ref_word,
   input wire logic bus_ref_write,
   input wire logic [15:0] drive_state_word,
   input wire logic status_valid,
   input wire logic signed [31:0] speed_ref_ppm,
   input wire logic speed_ref_reverse
);
   logic live;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   // last edge was native protocol out of reset, so the word mirrors those inputs
   always_ff @(posedge clk) begin
      live <= !reset && protocol_select == 8'h00;
   end
   ////////////////////////////////////////////////////////////////
   reserved_zero_a: assert property (drive_state_word[5] == 1'b0) else $error("reserved bit set");
   refused_word_a: assert property (!$past(reset) && $past(protocol_select) != 8'h00 |->
      drive_state_word == 16'h0000 && !status_valid) else $error("word shown for foreign protocol");
   warning_bit_a: assert property (live |-> drive_state_word[7] == $past(warning_any)) else $error("warning bit");
   voltage_bit_a: assert property (live |-> drive_state_word[13] == $past(dc_voltage_bad)) else $error("voltage bit");
   current_bit_a: assert property (live |-> drive_state_word[14] ==
      ($past(motor_current) > $past(current_limit))) else $error("current bit");
   trip_seen_a: assert property (trip_event && protocol_select == 8'h00 ##1 protocol_select == 8'h00 |=>
      drive_state_word[3] && !drive_state_word[0]) else $error("trip not shown");
   ref_sign_a: assert property (bus_ref_write |=> speed_ref_reverse == $past(bus_ref_word[15])) else $error("sign");
   full_scale_a: assert property (bus_ref_write && bus_ref_word == 16'h4000 |=>
      speed_ref_ppm == 32'sd1000000) else $error("full scale");
   // main scenarios
   cover property (trip_event);
   cover property (bus_ref_write && bus_ref_word[15]);
   cover property (status_valid && drive_state_word[14]);
endmodule

bind dsw_status_word dsw_checker chk_i (.clk, .reset, .protocol_select, .trip_event, .warning_any, .dc_voltage_bad,
   .motor_current, .current_limit, .bus_ref_word, .bus_ref_write, .drive_state_word, .status_valid,
   .speed_ref_ppm, .speed_ref_reverse);

//--- sim/dsw_master_model.sv
/*
 holds a behavioural fieldbus master that writes speed reference words.
 assumes the caller waits at a falling edge between uses.
*/
`timescale 1ns/1ps
module dsw_master_model (
   input wire logic clk,
   output logic [15:0] bus_ref_word,
   output logic bus_ref_write
);
   // quiet bus at time zero
   initial begin
      bus_ref_word = 16'h0000;
      bus_ref_write = 1'b0;
   end
   // one signed relative word per write, held up to the taking edge
   task automatic send(input logic [15:0] rel);
      @(negedge clk);
      bus_ref_word = rel;
      bus_ref_write = 1'b1;
      @(posedge clk);
   endtask
   // released lines show the inverse so a stale word never looks valid
   task automatic idle();
      @(negedge clk);
      bus_ref_write = 1'b0;
      bus_ref_word = ~bus_ref_word;
   endtask
endmodule

//--- sim/tb.sv
/*
 holds the self-checking bench of the status word block.
 assumes the master model and the bound checker are compiled alongside.
*/
`timescale 1ns/1ps
module tb;
   logic clk = 1'b0, reset = 1'b1, control_ready = 1'b0, power_ready = 1'b0, coast_active = 1'b0;
   logic start_cmd = 1'b0, trip_event = 1'b0, triplock_event = 1'b0, fault_reset = 1'b0, error_no_trip = 1'b0;
   logic warning_any = 1'b0, local_mode = 1'b0, local_off_key = 1'b0, overtemp_stop = 1'b0, dc_voltage_bad = 1'b0;
   logic [7:0] protocol_select = 8'h00;
   logic signed [15:0] output_freq = 16'h0000, speed_ref_freq = 16'h0000, low_limit = 16'h0000;
   logic signed [15:0] high_limit = 16'h0000, max_freq = 16'h03E8, actual_output_frequency_value, v;
   logic [15:0] motor_current = 16'h0000, current_limit = 16'h4000, motor_thermal = 16'h0000;
   logic [15:0] drive_thermal = 16'h0000, bus_ref_word, drive_state_word;
   logic [15:0] corner [5] = '{16'h4000, 16'hC000, 16'h0000, 16'h7F00, 16'h8000};
   logic bus_ref_write, status_valid, speed_ref_reverse;
   logic signed [31:0] speed_ref_ppm;
   int error_cnt = 0, n_tests = 0, cyc = 0;
   always #10 clk = ~clk;
   dsw_master_model master (.clk, .bus_ref_word, .bus_ref_write);
   dsw_status_word dut (.clk, .reset, .protocol_select, .control_ready, .power_ready, .coast_active, .start_cmd,
      .trip_event, .triplock_event, .fault_reset, .error_no_trip, .warning_any, .local_mode, .local_off_key,
      .overtemp_stop, .dc_voltage_bad, .output_freq, .speed_ref_freq, .low_limit, .high_limit, .max_freq,
      .motor_current, .current_limit, .motor_thermal, .drive_thermal, .bus_ref_word, .bus_ref_write,
      .drive_state_word, .status_valid, .actual_output_frequency_value, .speed_ref_ppm, .speed_ref_reverse);
   ////////////////////////////////////////////////////////////////
   // expected word while untripped; bit 01 means ready with coast still active
   function automatic logic [15:0] exp_word();
      return {motor_thermal > 16'h4000 || drive_thermal > 16'h4000, motor_current > current_limit, dc_voltage_bad,
         overtemp_stop, start_cmd && !coast_active, low_limit < output_freq && output_freq < high_limit, !local_mode,
         output_freq == speed_ref_freq, warning_any, 2'b00, error_no_trip, 1'b0, !coast_active,
         control_ready && power_ready && coast_active, control_ready};
   endfunction
   // relative frequency word, saturated to the signed range
   function automatic logic [15:0] exp_mav(input int f);
      int r;
      r = f * 16384 / int'(max_freq);
      return (r > 32767) ? 16'h7FFF : (r < -32768) ? 16'h8000 : 16'(r);
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      $display("mismatches %0d, checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      v = 16'($urandom(32'h9ce1ef7a));
      repeat (10) @(negedge clk);
      reset = 1'b0;
      // random levels; limits and thresholds straddle equality
      repeat (300) begin
         {control_ready, power_ready, coast_active, start_cmd, error_no_trip} = 5'($urandom);
         {warning_any, local_mode, overtemp_stop, dc_voltage_bad} = 4'($urandom);
         output_freq = 16'($urandom_range(0, 40));
         speed_ref_freq = 16'($urandom_range(0, 40));
         low_limit = 16'($urandom_range(0, 20));
         high_limit = 16'($urandom_range(20, 40));
         motor_current = 16'($urandom_range(16'h3FFE, 16'h4002));
         motor_thermal = 16'($urandom_range(16'h3FFE, 16'h4002));
         drive_thermal = 16'($urandom_range(16'h3FFE, 16'h4002));
         @(negedge clk);
         chk("state word", 32'(exp_word()), 32'(drive_state_word));
      end
      warning_any = 1'b1;
      protocol_select = 8'($urandom_range(1, 255));
      repeat (2) @(negedge clk);
      chk("refused word", 32'({status_valid, drive_state_word}), 32'h0);
      protocol_select = 8'h00;
      local_mode = 1'b0;
      local_off_key = 1'b1;
      repeat (8) @(negedge clk);
      chk("bus control", 32'(drive_state_word[9]), 32'h0);
      control_ready = 1'b1;
      pulse(trip_event);
      @(negedge clk);
      chk("tripped", 32'(drive_state_word & 16'h0009), 32'h8);
      pulse(fault_reset);
      repeat (2) @(negedge clk);
      chk("trip cleared", 32'(drive_state_word[3]), 32'h0);
      pulse(triplock_event);
      pulse(fault_reset);
      repeat (2) @(negedge clk);
      chk("locked", 32'(drive_state_word[6]), 32'h1);
      reset = 1'b1;
      @(negedge clk);
      reset = 1'b0;
      repeat (2) @(negedge clk);
      chk("lock cleared", 32'(drive_state_word[6]), 32'h0);
      // back-to-back reference writes, corners first
      for (int i = 0; i < 25; i++) begin
         v = (i < 5) ? corner[i] : 16'($urandom & 32'hFF00);
         master.send(v);
         #1 chk("ref ppm", (32'(v) * 15625) / 256, speed_ref_ppm);
         chk("ref sign", 32'(v[15]), 32'(speed_ref_reverse));
      end
      master.idle();
      for (int i = 0; i < 12; i++) begin
         output_freq = (i == 0) ? 16'sd2000 : 16'(125 * $urandom_range(0, 32)) - 16'sd2000;
         repeat (2) @(negedge clk);
         chk("actual freq", 32'(exp_mav(output_freq)), {16'h0000, actual_output_frequency_value});
      end
      close_out();
   end
endmodule
